// >>> pmmc_board.sv
// board model driving the pins of the macrocell block
`timescale 1ns/100ps
module pmmc_board (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pmmc_pkg::pmmc_pins_t want,
    input wire logic pulse,
    output pmmc_pkg::pmmc_pins_t pins,
    output logic busy
);
    logic [3:0] cnt_q;
    logic clk_q;
    logic [7:0] io_q;
    logic [7:0] ded_q;
    // four low cycles first so data is set up before the rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            clk_q <= 1'h0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            clk_q <= cnt_q <= 4'h4 && cnt_q > 4'h1;
        end else if (pulse) begin
            cnt_q <= 4'h7;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_q <= 8'h00;
            ded_q <= 8'h00;
        end else begin
            io_q <= pins.io;
            ded_q <= pins.ded;
        end
    end
    assign busy = cnt_q != 4'h0;
    // released ded and io lines toggle so a stale value never passes for a pull-up
    assign pins = '{clk: busy ? clk_q : want.clk, clk_drv: want.clk_drv,
        oe_n: want.oe_n, oe_drv: want.oe_drv,
        ded: (want.ded & want.ded_drv) | (~ded_q & ~want.ded_drv),
        ded_drv: want.ded_drv,
        io: (want.io & want.io_drv) | (~io_q & ~want.io_drv),
        io_drv: want.io_drv};
endmodule

// >>> pmmc_pkg.sv
// constants and types shared by the macrocell mode block
package pmmc_pkg;
    localparam int NUM_MC = 8;
    localparam int NUM_PT = 8;
    localparam int ADDR_W = 5;
    localparam int ARR_W = 18;
    localparam logic [4:0] OFF_MODE = 5'h00;
    localparam logic [4:0] OFF_MCCFG = 5'h04;
    localparam logic [4:0] OFF_FUSE = 5'h08;
    localparam logic [4:0] OFF_PRELOAD = 5'h0C;
    localparam logic [4:0] OFF_STATE = 5'h10;
    localparam logic [4:0] OFF_SIG_LO = 5'h14;
    localparam logic [4:0] OFF_SIG_HI = 5'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int CLK_PERIOD_NS = 40;
    localparam int PR_TIME_MAX_NS = 1000;
    localparam int PR_CYC = (PR_TIME_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MC_CLK_FB = 7;
    localparam int MC_OE_FB = 0;
    localparam int MC_INNER_LO = 3;
    localparam int MC_INNER_HI = 4;
    localparam int ARR_FB_LSB = 8;
    localparam int ARR_CLK = 16;
    localparam int ARR_OE = 17;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] MCCFG_RESET = 16'hFFFF;
    typedef enum logic [1:0] {
        MODE_REG = 2'b00,
        MODE_CPLX = 2'b01,
        MODE_SIMPLE = 2'b10
    } pmmc_mode_t;
    typedef enum logic [1:0] {
        MC_REG_OUT = 2'b00,
        MC_COMB_IO = 2'b01,
        MC_COMB_OUT = 2'b10,
        MC_DED_IN = 2'b11
    } pmmc_mccfg_t;
    typedef struct packed {
        logic clk;
        logic clk_drv;
        logic oe_n;
        logic oe_drv;
        logic [7:0] ded;
        logic [7:0] ded_drv;
        logic [7:0] io;
        logic [7:0] io_drv;
    } pmmc_pins_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pmmc_pad_t;
endpackage

// >>> pmmc_top.sv
// macrocell array with mode routing, preload, security and signature
`timescale 1ns/100ps
module pmmc_top #(
    parameter int PR_CYCLES = pmmc_pkg::PR_CYC
) (
    input logic aclk,
    input logic aresetn,
    input logic [pmmc_pkg::ADDR_W-1:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [pmmc_pkg::ADDR_W-1:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    input logic clk_pin,
    input logic clk_drv,
    input logic oe_n_pin,
    input logic oe_drv,
    input logic [7:0] ded_pin,
    input logic [7:0] ded_drv,
    input logic [7:0] io_pin,
    input logic [7:0] io_drv,
    input logic [63:0] pterm,
    output logic [7:0] io_out,
    output logic [7:0] io_oe,
    output logic [pmmc_pkg::ARR_W-1:0] array_in
);
    localparam int N = pmmc_pkg::NUM_MC;
    localparam int P = pmmc_pkg::NUM_PT;
    localparam int PR_W = $clog2(PR_CYCLES + 1);
    localparam logic [PR_W-1:0] PR_LAST = PR_W'(PR_CYCLES);

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] word(input logic [4:0] a);
        return {a[4:2], 2'b00};
    endfunction

    pmmc_pkg::pmmc_pins_t pin_raw, meta_q, sync_q;
    pmmc_pkg::pmmc_pad_t pad_d, pad_q;
    pmmc_pkg::pmmc_mode_t mode_q;
    logic [2*N-1:0] mccfg_q;
    logic [N-1:0] reg_q, reg_d, reg_mask, in_mask, cap_mask;
    logic [N-1:0] sum8, sum7, pt_oe, fb_d, io_v, ded_v;
    logic [PR_W-1:0] pr_cnt_q;
    logic pr_done, clk_v, oe_n_v, clk_prev_q, clk_rise;
    logic fuse_q;
    logic [63:0] sig_q;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_en, ar_take;
    logic sel_mode, sel_mccfg, sel_fuse, sel_pre, sel_lo, sel_hi, sel_st;
    logic [31:0] mode_wr, mccfg_wr, lo_wr, hi_wr;
    logic preload_hit;
    logic [pmmc_pkg::ARR_W-1:0] array_d, array_q;

    // pins cross in through two flops before anything reads them
    assign pin_raw = {clk_pin, clk_drv, oe_n_pin, oe_drv,
                      ded_pin, ded_drv, io_pin, io_drv};
    always_ff @(posedge aclk) begin
        meta_q <= pin_raw;
        sync_q <= meta_q;
    end

    // weak pull-ups: undriven pins read high
    assign clk_v = ~sync_q.clk_drv | sync_q.clk;
    assign oe_n_v = ~sync_q.oe_drv | sync_q.oe_n;
    assign ded_v = ~sync_q.ded_drv | sync_q.ded;
    assign io_v = (pad_q.oe & pad_q.out) |
                  (~pad_q.oe & (~sync_q.io_drv | sync_q.io));

    // clock edges inside the reset window are not trusted
    assign pr_done = pr_cnt_q == PR_LAST;
    assign clk_rise = clk_v & ~clk_prev_q & pr_done;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            sum8[i] = |pterm[i*P +: P];
            sum7[i] = |pterm[i*P+1 +: P-1];
            pt_oe[i] = pterm[i*P];
            reg_mask[i] = mccfg_q[2*i +: 2] == pmmc_pkg::MC_REG_OUT;
            in_mask[i] = mccfg_q[2*i +: 2] == pmmc_pkg::MC_DED_IN;
        end
    end

    // per-mode output, enable and feedback routing
    always_comb begin
        pad_d = '0;
        fb_d = '1;
        for (int i = 0; i < N; i++) begin
            case (mode_q)
                pmmc_pkg::MODE_REG: begin
                    if (reg_mask[i]) begin
                        pad_d.out[i] = ~reg_q[i];
                        pad_d.oe[i] = ~oe_n_v;
                        fb_d[i] = reg_q[i];
                    end else if (in_mask[i]) begin
                        fb_d[i] = io_v[i];
                    end else begin
                        pad_d.out[i] = sum7[i];
                        pad_d.oe[i] = pt_oe[i];
                        fb_d[i] = io_v[i];
                    end
                end
                pmmc_pkg::MODE_CPLX: begin
                    pad_d.out[i] = sum7[i];
                    pad_d.oe[i] = pt_oe[i] & (~in_mask[i] |
                        i == pmmc_pkg::MC_CLK_FB | i == pmmc_pkg::MC_OE_FB);
                    fb_d[i] = io_v[i];
                end
                default: begin
                    pad_d.out[i] = sum8[i];
                    pad_d.oe[i] = ~in_mask[i] |
                        i == pmmc_pkg::MC_INNER_LO | i == pmmc_pkg::MC_INNER_HI;
                    if (i != pmmc_pkg::MC_INNER_LO &&
                        i != pmmc_pkg::MC_INNER_HI) begin
                        fb_d[i] = io_v[i];
                    end
                end
            endcase
        end
        if (mode_q == pmmc_pkg::MODE_CPLX) begin
            fb_d[pmmc_pkg::MC_CLK_FB] = clk_v;
            fb_d[pmmc_pkg::MC_OE_FB] = oe_n_v;
        end
    end

    // clock and enable columns only live in simple mode
    assign array_d = {mode_q == pmmc_pkg::MODE_SIMPLE ? oe_n_v : 1'b1,
                      mode_q == pmmc_pkg::MODE_SIMPLE ? clk_v : 1'b1,
                      fb_d, ded_v};

    // preload wins over a clock edge in the same cycle
    assign preload_hit = wr_en & sel_pre & wstrb_q[0] & ~fuse_q;
    assign cap_mask = (mode_q == pmmc_pkg::MODE_REG && clk_rise) ?
                      reg_mask : '0;
    assign reg_d = preload_hit ? wdata_q[7:0] :
                   (reg_q & ~cap_mask) | (sum8 & cap_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_q <= pmmc_pkg::REG_RESET;
            pr_cnt_q <= '0;
            clk_prev_q <= 1'b1;
            pad_q <= '{out: '1, oe: '0};
            array_q <= '1;
        end else begin
            reg_q <= reg_d;
            pr_cnt_q <= pr_done ? pr_cnt_q : pr_cnt_q + 1'b1;
            clk_prev_q <= clk_v;
            pad_q <= pad_d;
            array_q <= array_d;
        end
    end

    // bus write side: address and data taken in either order
    assign wr_en = ~awready_q & ~wready_q & ~bvalid_q;
    assign sel_mode = word(awaddr_q) == pmmc_pkg::OFF_MODE;
    assign sel_mccfg = word(awaddr_q) == pmmc_pkg::OFF_MCCFG;
    assign sel_fuse = word(awaddr_q) == pmmc_pkg::OFF_FUSE;
    assign sel_pre = word(awaddr_q) == pmmc_pkg::OFF_PRELOAD;
    assign sel_st = word(awaddr_q) == pmmc_pkg::OFF_STATE;
    assign sel_lo = word(awaddr_q) == pmmc_pkg::OFF_SIG_LO;
    assign sel_hi = word(awaddr_q) == pmmc_pkg::OFF_SIG_HI;
    assign mode_wr = merge({30'h0, mode_q}, wdata_q, wstrb_q);
    assign mccfg_wr = merge({16'h0, mccfg_q}, wdata_q, wstrb_q);
    assign lo_wr = merge(sig_q[31:0], wdata_q, wstrb_q);
    assign hi_wr = merge(sig_q[63:32], wdata_q, wstrb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= pmmc_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            mode_q <= pmmc_pkg::MODE_REG;
            mccfg_q <= pmmc_pkg::MCCFG_RESET;
            fuse_q <= 1'b0;
            sig_q <= '0;
        end else begin
            if (awvalid && awready_q) begin
                awaddr_q <= awaddr;
                awready_q <= 1'b0;
            end
            if (wvalid && wready_q) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                wready_q <= 1'b0;
            end
            if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
            if (wr_en) begin
                bvalid_q <= 1'b1;
                bresp_q <= pmmc_pkg::RESP_OKAY;
                if (sel_mode) begin
                    // the unused code would leave no mode, so it is dropped
                    if (mode_wr[1:0] != 2'b11) begin
                        mode_q <= pmmc_pkg::pmmc_mode_t'(mode_wr[1:0]);
                    end
                end else if (sel_mccfg) begin
                    mccfg_q <= mccfg_wr[15:0];
                end else if (sel_fuse) begin
                    // one-way: only a reset brings it back
                    fuse_q <= fuse_q | (wstrb_q[0] & wdata_q[0]);
                end else if (sel_pre) begin
                    if (fuse_q) begin
                        bresp_q <= pmmc_pkg::RESP_SLVERR;
                    end
                end else if (sel_lo) begin
                    sig_q[31:0] <= lo_wr;
                end else if (sel_hi) begin
                    sig_q[63:32] <= hi_wr;
                end else if (!sel_st) begin
                    bresp_q <= pmmc_pkg::RESP_DECERR;
                end
            end
        end
    end

    // bus read side
    assign ar_take = arvalid & arready_q;
    always_comb begin
        rdata_d = '0;
        rresp_d = pmmc_pkg::RESP_OKAY;
        if (word(araddr) == pmmc_pkg::OFF_MODE) begin
            rdata_d = {30'h0, mode_q};
        end else if (word(araddr) == pmmc_pkg::OFF_MCCFG) begin
            rdata_d = {16'h0, mccfg_q};
        end else if (word(araddr) == pmmc_pkg::OFF_FUSE) begin
            rdata_d = {30'h0, pr_done, fuse_q};
        end else if (word(araddr) == pmmc_pkg::OFF_STATE) begin
            rdata_d = {24'h0, reg_q};
        end else if (word(araddr) == pmmc_pkg::OFF_SIG_LO) begin
            rdata_d = sig_q[31:0];
        end else if (word(araddr) == pmmc_pkg::OFF_SIG_HI) begin
            rdata_d = sig_q[63:32];
        end else if (word(araddr) != pmmc_pkg::OFF_PRELOAD) begin
            rresp_d = pmmc_pkg::RESP_DECERR;
        end
        if (fuse_q && (word(araddr) == pmmc_pkg::OFF_MODE ||
            word(araddr) == pmmc_pkg::OFF_MCCFG ||
            word(araddr) == pmmc_pkg::OFF_STATE)) begin
            rdata_d = '0;
            rresp_d = pmmc_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= pmmc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign io_out = pad_q.out;
    assign io_oe = pad_q.oe;
    assign array_in = array_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fuse_write;
        wr_en && sel_fuse && wstrb_q[0] && wdata_q[0];
    endsequence
    sequence s_reg_edge;
        mode_q == pmmc_pkg::MODE_REG && clk_rise && !preload_hit;
    endsequence

    property p_reset_clear;
        $rose(aresetn) |-> reg_q == pmmc_pkg::REG_RESET && pad_q.out == '1;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset");
    property p_preload;
        preload_hit |=> reg_q == $past(wdata_q[7:0]);
    endproperty
    a_preload: assert property (p_preload) else $error("preload");
    property p_secure_read;
        fuse_q && ar_take && word(araddr) == pmmc_pkg::OFF_STATE
        |=> rvalid_q && rdata_q == '0 && rresp_q == pmmc_pkg::RESP_SLVERR;
    endproperty
    a_secure_read: assert property (p_secure_read) else $error("read");
    property p_fuse_now;
        s_fuse_write |=> fuse_q;
    endproperty
    a_fuse_now: assert property (p_fuse_now) else $error("fuse");
    property p_pre_lock;
        fuse_q && wr_en && sel_pre && cap_mask == '0 |=> $stable(reg_q);
    endproperty
    a_pre_lock: assert property (p_pre_lock) else $error("lock");
    property p_sig_read;
        ar_take && word(araddr) == pmmc_pkg::OFF_SIG_HI
        |=> rdata_q == $past(sig_q[63:32]) && rresp_q == pmmc_pkg::RESP_OKAY;
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signature");
    property p_reg_oe;
        mode_q == pmmc_pkg::MODE_REG |=> (pad_q.oe & $past(reg_mask)) ==
            ({N{~$past(oe_n_v)}} & $past(reg_mask));
    endproperty
    a_reg_oe: assert property (p_reg_oe) else $error("enable pin");
    property p_cplx_fb;
        mode_q == pmmc_pkg::MODE_CPLX |=> array_q[pmmc_pkg::ARR_FB_LSB +
            pmmc_pkg::MC_CLK_FB] == $past(clk_v);
    endproperty
    a_cplx_fb: assert property (p_cplx_fb) else $error("complex fb");
    property p_inner_on;
        mode_q == pmmc_pkg::MODE_SIMPLE |=> pad_q.oe[pmmc_pkg::MC_INNER_LO]
            && pad_q.oe[pmmc_pkg::MC_INNER_HI];
    endproperty
    a_inner_on: assert property (p_inner_on) else $error("inner");
    property p_capture;
        s_reg_edge |=> (reg_q & $past(reg_mask)) ==
            ($past(sum8) & $past(reg_mask)) ##1
            (pad_q.out & $past(reg_mask, 2)) ==
            (~$past(reg_q) & $past(reg_mask, 2))
            || $past(mode_q) != pmmc_pkg::MODE_REG
            || $past(reg_mask) != $past(reg_mask, 2);
    endproperty
    a_capture: assert property (p_capture) else $error("capture");
endmodule

// >>> tb.sv
// self-checking bench for the macrocell mode block
`timescale 1ns/100ps
module tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pulse, busy;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, rd, r32;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [63:0] pterm, sig;
    logic [7:0] io_out, io_oe, st, b;
    logic [pmmc_pkg::ARR_W-1:0] array_in;
    logic [15:0] cfg;
    logic [23:0] e;
    pmmc_pkg::pmmc_pins_t want, pins;
    int fails, checked, n, m;
    pmmc_top #(.PR_CYCLES(3)) u_dut (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .clk_pin(pins.clk), .clk_drv(pins.clk_drv), .oe_n_pin(pins.oe_n),
        .oe_drv(pins.oe_drv), .ded_pin(pins.ded), .ded_drv(pins.ded_drv),
        .io_pin(pins.io), .io_drv(pins.io_drv), .pterm, .io_out, .io_oe,
        .array_in);
    pmmc_board u_board (.aclk, .aresetn, .want, .pulse, .pins, .busy);
    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] orb(logic [63:0] p);
        for (int i = 0; i < 8; i++) orb[i] = |p[8*i+:8];
    endfunction
    // {drive-mask, out, oe} per mode; masked bits are inputs
    function automatic logic [23:0] model(int md, logic [15:0] c,
        logic [63:0] p, logic [7:0] s);
        logic [7:0] oe, out, mk;
        logic [1:0] f;
        logic [7:0] t;
        for (int i = 0; i < 8; i++) begin
            f = c[2*i+:2];
            t = p[8*i+:8];
            oe[i] = t[0];
            out[i] = |t[7:1];
            mk[i] = 1'h1;
            if (md == 0 && f == 2'h0) begin
                oe[i] = 1'h1;
                out[i] = ~s[i];
            end
            if (f == 2'h3 && !(md == 1 && (i == 0 || i == 7))) begin
                oe[i] = 1'h0;
                mk[i] = 1'h0;
            end
            if (md == 2) begin
                out[i] = |t;
                oe[i] = f != 2'h3 || i == 3 || i == 4;
                mk[i] = oe[i];
            end
        end
        return {mk, out, oe};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic timeout();
        fails++;
        $display("MISMATCH t=%0t wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            k++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!(bready && bvalid) && k < 40);
        if (k >= 40) timeout();
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic axr(input logic [4:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            k++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!(rready && rvalid) && k < 40);
        if (k >= 40) timeout();
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask
    initial begin
        seed = 32'h000116A0;
        fails = 0;
        checked = 0;
        aresetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready, pulse} = 6'h00;
        awaddr = 5'h00;
        araddr = 5'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        pterm = 64'h0;
        want = '0;
        want.oe_drv = 1'h1;
        want.clk_drv = 1'h1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk(io_out, 8'hFF);
        chk(io_oe, 8'h00);
        rd = 32'h0;
        n = 0;
        // clock pin stays still until the reset window reports done
        while (!rd[1] && n < 20) begin
            axr(pmmc_pkg::OFF_FUSE, rd, rs);
            n++;
        end
        if (!rd[1]) timeout();
        sig = {rnd(), rnd()};
        axw(pmmc_pkg::OFF_SIG_LO, sig[31:0], rs);
        axw(pmmc_pkg::OFF_SIG_HI, sig[63:32], rs);
        axr(pmmc_pkg::OFF_SIG_HI, rd, rs);
        chk(rd, sig[63:32]);
        axw(pmmc_pkg::OFF_MODE, 32'h0, rs);
        axw(pmmc_pkg::OFF_MCCFG, 32'h0, rs);
        pterm <= {rnd(), rnd()};
        pulse <= 1'h1;
        @(posedge aclk);
        pulse <= 1'h0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (busy && n < 20);
        if (busy) timeout();
        settle();
        st = orb(pterm);
        chk(io_out, 8'(~st));
        chk(io_oe, 8'hFF);
        axr(pmmc_pkg::OFF_STATE, rd, rs);
        chk(rd[7:0], st);
        pterm <= {rnd(), rnd()};
        want.oe_n <= 1'h1;
        settle();
        chk(io_out, 8'(~st));
        chk(io_oe, 8'h00);
        want.oe_n <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            r32 = rnd();
            b = k == 0 ? 8'h00 : k == 1 ? 8'hFF : r32[7:0];
            axw(pmmc_pkg::OFF_PRELOAD, {24'h0, b}, rs);
            chk(rs, pmmc_pkg::RESP_OKAY);
            axr(pmmc_pkg::OFF_STATE, rd, rs);
            chk(rd[7:0], b);
            chk(io_out, 8'(~b));
        end
        st = b;
        for (int k = 0; k < 6; k++) begin
            m = k % 3;
            r32 = rnd();
            cfg = r32[15:0];
            axw(pmmc_pkg::OFF_MODE, m, rs);
            axw(pmmc_pkg::OFF_MCCFG, {16'h0, cfg}, rs);
            pterm <= {rnd(), rnd()};
            want.ded <= r32[23:16];
            want.ded_drv <= r32[31:24];
            want.clk <= m == 1 ? r32[16] : 1'h0;
            want.oe_n <= m == 0 ? 1'h0 : r32[17];
            r32 = rnd();
            want.io <= r32[7:0];
            want.io_drv <= r32[15:8];
            settle();
            e = model(m, cfg, pterm, st);
            chk(io_oe, e[7:0]);
            chk(io_out & e[23:16], e[15:8] & e[23:16]);
            b = want.ded | ~want.ded_drv;
            chk(array_in[7:0], b);
            rs = m == 2 ? {want.oe_n, want.clk} : 2'h3;
            chk(array_in[17:16], rs);
            rs = {array_in[15], array_in[8]};
            if (m == 1) chk(rs, {want.clk, want.oe_n});
            if (m == 2) chk(array_in[12:11], 2'h3);
            // undriven simple-mode pads feed back the pin, pulled up
            b = m == 2 ? ~e[7:0] : 8'h00;
            chk(array_in[15:8] & b, (want.io | ~want.io_drv) & b);
        end
        axw(pmmc_pkg::OFF_MODE, 32'h3, rs);
        chk(rs, pmmc_pkg::RESP_OKAY);
        axr(pmmc_pkg::OFF_MODE, rd, rs);
        chk(rd[1:0], 2'h2);
        axw(pmmc_pkg::OFF_MODE, 32'h0, rs);
        axw(pmmc_pkg::OFF_MCCFG, 32'h0, rs);
        want.oe_n <= 1'h0;
        axw(pmmc_pkg::OFF_FUSE, 32'h1, rs);
        axr(pmmc_pkg::OFF_MODE, rd, rs);
        chk({rs, rd}, {pmmc_pkg::RESP_SLVERR, 32'h0});
        axr(pmmc_pkg::OFF_MCCFG, rd, rs);
        chk({rs, rd}, {pmmc_pkg::RESP_SLVERR, 32'h0});
        axr(pmmc_pkg::OFF_STATE, rd, rs);
        chk({rs, rd}, {pmmc_pkg::RESP_SLVERR, 32'h0});
        axw(pmmc_pkg::OFF_PRELOAD, {24'h0, ~st}, rs);
        chk(rs, pmmc_pkg::RESP_SLVERR);
        settle();
        chk(io_out, 8'(~st));
        axr(pmmc_pkg::OFF_SIG_LO, rd, rs);
        chk({rs, rd}, {pmmc_pkg::RESP_OKAY, sig[31:0]});
        axw(pmmc_pkg::OFF_SIG_HI, ~sig[63:32], rs);
        axr(pmmc_pkg::OFF_SIG_HI, rd, rs);
        chk({rs, rd}, {pmmc_pkg::RESP_OKAY, ~sig[63:32]});
        axr(5'h1C, rd, rs);
        chk(rs, pmmc_pkg::RESP_DECERR);
        tally_and_finish();
    end
endmodule
